/* sol_pkg.sv */
package sol_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 16;
    localparam int          NUM_STRAP  = 10;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  CTRL_OFF   = 8'h00;
    localparam logic [7:0]  ADV_OFF    = 8'h04;
    localparam logic [7:0]  STAT_OFF   = 8'h08;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int          CTRL_SPEED_BIT  = 13;
    localparam int          CTRL_ANEG_BIT   = 12;
    localparam int          CTRL_ISO_BIT    = 10;
    localparam int          CTRL_DUPLEX_BIT = 8;
    localparam logic [15:0] CTRL_WR_MASK    = 16'h3500;

    // ------------------------------------------------------------
    // Advertisement register fields
    // ------------------------------------------------------------
    localparam int          ADV_100FD_BIT   = 8;
    localparam int          ADV_100HD_BIT   = 7;
    localparam int          ADV_10FD_BIT    = 6;
    localparam int          ADV_10HD_BIT    = 5;
    localparam logic [4:0]  ADV_SELECTOR    = 5'h01;
    localparam logic [15:0] ADV_WR_MASK     = 16'h01E0;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int          STAT_MODE_LSB   = 5;
    localparam int          STAT_RSVD_BIT   = 8;
    localparam int          STAT_DONE_BIT   = 9;

    // ------------------------------------------------------------
    // Strap pin positions in the pin vector
    // ------------------------------------------------------------
    localparam int          STRAP_ADDR_LSB  = 0;
    localparam int          STRAP_MODE_LSB  = 3;
    localparam int          STRAP_ISO       = 6;
    localparam int          STRAP_SPEED     = 7;
    localparam int          STRAP_DUPLEX    = 8;
    localparam int          STRAP_ANEG      = 9;
    localparam logic [9:0]  PULL_UP_MASK    = 10'h381;
    localparam int          PULL_KOHM       = 40;

    // ------------------------------------------------------------
    // Address and mode codes
    // ------------------------------------------------------------
    localparam logic [1:0]  ADDR_UPPER      = 2'h0;
    localparam logic [2:0]  MODE_MII        = 3'h0;
    localparam logic [2:0]  MODE_PRE_REST   = 3'h4;

    typedef enum logic [1:0] {
        SOL_MODE_MII,
        SOL_MODE_PREAMBLE,
        SOL_MODE_RESERVED
    } sol_mode_t;
endpackage : sol_pkg

/* sol_strap_board.sv */
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// Board pulls and a controller on the dual-role strap pins
// ------------------------------------------------------------
module sol_strap_board
    import sol_pkg::*;
(
    // Clock
    input  wire logic                 clk,
    // Device pin side
    input  wire logic [NUM_STRAP-1:0] strap_pin_out,
    input  wire logic [NUM_STRAP-1:0] strap_pin_oe,
    input  wire logic [NUM_STRAP-1:0] strap_pull_up_en,
    input  wire logic [NUM_STRAP-1:0] strap_pull_dn_en,
    // Controller drive, only where the bench commands it
    input  wire logic [NUM_STRAP-1:0] drive_en,
    input  wire logic [NUM_STRAP-1:0] drive_val,
    output logic      [NUM_STRAP-1:0] strap_pin_in
);
    logic [NUM_STRAP-1:0] float_pat = 10'h155;

    // Undriven pins wander, so a stale level never passes for a strap
    always_ff @(posedge clk) begin
        float_pat <= ~float_pat;
    end

    // Wire level: device drive first, then controller, then weak pulls
    always_comb begin
        for (int i = 0; i < NUM_STRAP; i++) begin
            if (strap_pin_oe[i])
                strap_pin_in[i] = strap_pin_out[i];
            else if (drive_en[i])
                strap_pin_in[i] = drive_val[i];  // (high only when a scenario asks)
            else if (strap_pull_up_en[i])
                strap_pin_in[i] = 1'b1;
            else if (strap_pull_dn_en[i])
                strap_pin_in[i] = 1'b0;
            else
                strap_pin_in[i] = float_pat[i];
        end
    end
endmodule : sol_strap_board
`default_nettype wire

/* sol_strap_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface sol_strap_if;
    import sol_pkg::*;
    logic                 in_reset;
    logic [NUM_STRAP-1:0] pin_in;
    logic [NUM_STRAP-1:0] func_out;
    logic [NUM_STRAP-1:0] level;
    logic [NUM_STRAP-1:0] pin_out;
    logic [NUM_STRAP-1:0] pin_oe;
    logic [NUM_STRAP-1:0] pull_up;
    logic [NUM_STRAP-1:0] pull_dn;

    modport pad  (input in_reset, pin_in, func_out, output level, pin_out, pin_oe, pull_up, pull_dn);
    modport core (output in_reset, pin_in, func_out, input level, pin_out, pin_oe, pull_up, pull_dn);
endinterface : sol_strap_if
`default_nettype wire

/* sol_strap_option_latch.sv */
// Notes on behaviour
// RULE_01: Strap levels captured during power-up or chip reset, never resampled afterwards.
// RULE_02: Strap pins are weakly pulled inputs in reset, driven outputs after it.
// RULE_03: Three address straps form the low management address bits, values 1..7.
// RULE_04: Address straps left at their pulls give management address 00001.
// RULE_05: Upper two management address bits always read zero.
// RULE_06: Mode 000 is plain MII, 100 is preamble restore; others reserved.
// RULE_07: Isolate strap high enables isolate, loaded into control bit 10.
// RULE_08: Speed strap high selects 100 Mbps, loaded into control bit 13.
// RULE_09: Speed strap also sets the advertised speed capability bits.
// RULE_10: Duplex strap high means half duplex, loaded into control bit 8.
// RULE_11: Autoneg strap high enables auto-negotiation, loaded into control bit 12.
// RULE_12: Outside logic must not drive strap pins high during reset. The bench's test_straps drives them high through drive_en and drive_val.
// RULE_13: Strap-loaded bits hold until software writes them or reset recurs.
`timescale 1ns/10ps
`default_nettype none
module sol_strap_option_latch
    import sol_pkg::*;
(
    // Clock and resets
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 chip_reset_n,
    // Register port
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    // Strap pins
    input  wire logic [NUM_STRAP-1:0] strap_pin_in,
    output logic      [NUM_STRAP-1:0] strap_pin_out,
    output logic      [NUM_STRAP-1:0] strap_pin_oe,
    output logic      [NUM_STRAP-1:0] strap_pull_up_en,
    output logic      [NUM_STRAP-1:0] strap_pull_dn_en,
    // Normal pin functions after reset
    input  wire logic [NUM_STRAP-1:0] pin_func_out,
    // Configuration results
    output logic      [4:0]           mgmt_address,
    output logic                      preamble_restore,
    output logic                      isolate_en,
    output logic                      speed_100,
    output logic                      full_duplex,
    output logic                      autoneg_en
);
    // ------------------------------------------------------------
    // Pad carrier
    // ------------------------------------------------------------
    sol_strap_if sp ();

    logic in_reset;
    assign in_reset    = reset | ~chip_reset_n;
    assign sp.in_reset = in_reset;
    assign sp.pin_in   = strap_pin_in;
    assign sp.func_out = pin_func_out;

    sol_strap_pad u_pad (
        .clk   (clk),
        .reset (reset),
        .sp    (sp)
    );

    // Pad flops drive the pins directly
    assign strap_pin_out    = sp.pin_out;
    assign strap_pin_oe     = sp.pin_oe;
    assign strap_pull_up_en = sp.pull_up;
    assign strap_pull_dn_en = sp.pull_dn;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [15:0] ctrl_reg;
    logic [15:0] ctrl_next;
    logic [15:0] adv_reg;
    logic [15:0] adv_next;
    logic [4:0]  addr_reg;
    logic [2:0]  mode_reg;
    logic        done_reg;
    sol_mode_t   mode_dec;
    logic        wr_ctrl;
    logic        wr_adv;

    assign wr_ctrl = reg_wr & (reg_addr == CTRL_OFF);
    assign wr_adv  = reg_wr & (reg_addr == ADV_OFF);

    // Strap image of the control register
    always_comb begin
        ctrl_next                  = 16'h0000;
        ctrl_next[CTRL_SPEED_BIT]  = strap_pin_in[STRAP_SPEED];   // see RULE_08
        ctrl_next[CTRL_ANEG_BIT]   = strap_pin_in[STRAP_ANEG];    // see RULE_11
        ctrl_next[CTRL_ISO_BIT]    = strap_pin_in[STRAP_ISO];     // see RULE_07
        ctrl_next[CTRL_DUPLEX_BIT] = ~strap_pin_in[STRAP_DUPLEX]; // see RULE_10
    end

    // Strap image of the advertisement register; 10 Mbps is always offered
    always_comb begin
        adv_next                = {11'h000, ADV_SELECTOR};
        adv_next[ADV_100FD_BIT] = strap_pin_in[STRAP_SPEED]; // see RULE_09
        adv_next[ADV_100HD_BIT] = strap_pin_in[STRAP_SPEED]; // see RULE_09
        adv_next[ADV_10FD_BIT]  = 1'b1;
        adv_next[ADV_10HD_BIT]  = 1'b1;
    end

    // Control register: strap load wins over software while in reset
    always_ff @(posedge clk) begin
        if (in_reset) begin
            ctrl_reg <= ctrl_next; // see RULE_01
        end else if (wr_ctrl) begin
            ctrl_reg <= reg_wdata & CTRL_WR_MASK; // see RULE_13
        end
    end

    // Advertisement register, selector field is fixed
    always_ff @(posedge clk) begin
        if (in_reset) begin
            adv_reg <= adv_next;
        end else if (wr_adv) begin
            adv_reg <= (reg_wdata & ADV_WR_MASK) | {11'h000, ADV_SELECTOR}; // see RULE_13
        end
    end

    // Address and mode latch; no resample once reset is over
    always_ff @(posedge clk) begin
        if (in_reset) begin
            addr_reg <= {ADDR_UPPER, strap_pin_in[STRAP_ADDR_LSB +: 3]}; // see RULE_03 RULE_05
            mode_reg <= strap_pin_in[STRAP_MODE_LSB +: 3];               // see RULE_01
        end
    end

    // Marks that the straps are settled
    always_ff @(posedge clk) begin
        if (in_reset) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b1;
        end
    end

    // Mode decode; codes other than 000 and 100 decode to SOL_MODE_RESERVED
    always_comb begin
        case (mode_reg)
            MODE_MII:      mode_dec = SOL_MODE_MII;      // see RULE_06
            MODE_PRE_REST: mode_dec = SOL_MODE_PREAMBLE; // see RULE_06
            default:       mode_dec = SOL_MODE_RESERVED;
        endcase
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            mgmt_address     <= 5'h01;
            preamble_restore <= 1'b0;
            isolate_en       <= 1'b0;
            speed_100        <= 1'b1;
            full_duplex      <= 1'b0;
            autoneg_en       <= 1'b1;
        end else begin
            mgmt_address     <= addr_reg; // see RULE_04
            preamble_restore <= (mode_dec == SOL_MODE_PREAMBLE);
            isolate_en       <= ctrl_reg[CTRL_ISO_BIT];
            speed_100        <= ctrl_reg[CTRL_SPEED_BIT];
            full_duplex      <= ctrl_reg[CTRL_DUPLEX_BIT];
            autoneg_en       <= ctrl_reg[CTRL_ANEG_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read port, data one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                CTRL_OFF: reg_rdata <= ctrl_reg;
                ADV_OFF:  reg_rdata <= adv_reg;
                STAT_OFF: reg_rdata <= {6'h00, done_reg, (mode_dec == SOL_MODE_RESERVED), mode_reg, addr_reg};
                default:  reg_rdata <= 16'h0000; // Unmapped reads as zero
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Captured pad levels never move outside reset
    AST_NO_RESAMPLE: assert property (@(posedge clk) disable iff (reset) // see RULE_01
        !in_reset && !$past(in_reset) |-> $stable(sp.level) && $stable(addr_reg) && $stable(mode_reg))
        else $error("strap level changed after reset");

    // Pins sit on their weak pulls during reset and drive one cycle after release
    AST_PIN_ROLE: assert property (@(posedge clk) disable iff (reset) // see RULE_02
        $past(in_reset) |-> strap_pin_oe == '0 && (strap_pull_up_en | strap_pull_dn_en) == '1)
        else $error("strap pin driven during reset");

    AST_PIN_DRIVE: assert property (@(posedge clk) disable iff (reset) // see RULE_02
        !in_reset ##1 !in_reset |-> strap_pin_oe == '1 && strap_pin_out == $past(pin_func_out))
        else $error("strap pin not driving after reset");

    // Address low bits follow the straps, upper bits stay zero
    AST_ADDR_LOW: assert property (@(posedge clk) disable iff (reset) // see RULE_03
        $past(in_reset) |-> addr_reg[2:0] == $past(strap_pin_in[2:0]))
        else $error("address low bits not latched");

    AST_ADDR_DEFAULT: assert property (@(posedge clk) disable iff (reset) // see RULE_04
        in_reset && strap_pin_in[2:0] == 3'h1 ##1 !in_reset |=> mgmt_address == 5'h01)
        else $error("default address not 00001");

    AST_ADDR_UPPER: assert property (@(posedge clk) disable iff (reset) // see RULE_05
        mgmt_address[4:3] == 2'h0 && addr_reg[4:3] == 2'h0 && reg_rdata[4:3] == 2'h0)
        else $error("upper address bits not zero");

    AST_MODE: assert property (@(posedge clk) disable iff (reset) // see RULE_06
        $past(in_reset, 2) && !$past(in_reset) |-> preamble_restore == ($past(strap_pin_in[5:3], 2) == 3'h4))
        else $error("mode decode wrong");

    AST_CTRL_LOAD: assert property (@(posedge clk) disable iff (reset) // see RULE_07
        $past(in_reset) |-> ctrl_reg[10] == $past(strap_pin_in[6]) && ctrl_reg[13] == $past(strap_pin_in[7])
            && ctrl_reg[12] == $past(strap_pin_in[9]) && ctrl_reg[8] == !$past(strap_pin_in[8]))
        else $error("control bits not loaded from straps");

    AST_CTRL_OUT: assert property (@(posedge clk) disable iff (reset) // see RULE_08
        !in_reset ##1 !in_reset |-> speed_100 == $past(ctrl_reg[13]) && full_duplex == $past(ctrl_reg[8]))
        else $error("speed or duplex output mismatch");

    AST_ADV: assert property (@(posedge clk) disable iff (reset) // see RULE_09
        $past(in_reset) |-> adv_reg[8:7] == {2{$past(strap_pin_in[7])}} && adv_reg[4:0] == 5'h01)
        else $error("advertised speed not from strap");

    AST_HOLD: assert property (@(posedge clk) disable iff (reset) // see RULE_13
        !in_reset && !reg_wr |=> $stable(ctrl_reg) && $stable(adv_reg))
        else $error("strap bits changed without write");

    // Isolate and autoneg outputs lag the register by one cycle
    AST_OPT_OUT: assert property (@(posedge clk) disable iff (reset) // see RULE_11
        !$past(reset) |-> isolate_en == $past(ctrl_reg[CTRL_ISO_BIT]) && autoneg_en == $past(ctrl_reg[CTRL_ANEG_BIT]))
        else $error("isolate or autoneg output mismatch");

    // Duplex pin high means half, so bit 8 is its inverse
    AST_DUPLEX_LOAD: assert property (@(posedge clk) disable iff (reset) // see RULE_10
        $past(in_reset) |-> ctrl_reg[CTRL_DUPLEX_BIT] == !$past(strap_pin_in[STRAP_DUPLEX]))
        else $error("duplex bit not loaded from strap");

    // Autoneg enable follows its strap level
    AST_ANEG_LOAD: assert property (@(posedge clk) disable iff (reset) // see RULE_11
        $past(in_reset) |-> ctrl_reg[CTRL_ANEG_BIT] == $past(strap_pin_in[STRAP_ANEG]))
        else $error("autoneg bit not loaded from strap");

    // Speed select follows its strap level
    AST_SPEED_LOAD: assert property (@(posedge clk) disable iff (reset) // see RULE_08
        $past(in_reset) |-> ctrl_reg[CTRL_SPEED_BIT] == $past(strap_pin_in[STRAP_SPEED]))
        else $error("speed bit not loaded from strap");

    // Pull pattern during reset gives the default straps
    AST_PULL_MASK: assert property (@(posedge clk) disable iff (reset) // see RULE_04
        $past(in_reset) |-> strap_pull_up_en == PULL_UP_MASK && strap_pull_dn_en == ~PULL_UP_MASK)
        else $error("strap pull pattern wrong during reset");

    // Pulls drop once the pins turn into outputs
    AST_PULL_OFF: assert property (@(posedge clk) disable iff (reset) // see RULE_02
        !$past(in_reset) |-> strap_pull_up_en == '0 && strap_pull_dn_en == '0)
        else $error("strap pull left on after reset");

    // No stray drive value while the pin is an input
    AST_PIN_OUT_RST: assert property (@(posedge clk) disable iff (reset) // see RULE_02
        $past(in_reset) |-> strap_pin_out == '0)
        else $error("strap pin value not idle during reset");

    // Settled flag is low one cycle behind the window in which straps are sampled
    AST_DONE: assert property (@(posedge clk) disable iff (reset) // see RULE_01
        done_reg == !$past(in_reset))
        else $error("strap settled flag wrong");

    // Preamble restore output follows the latched code
    AST_MODE_OUT: assert property (@(posedge clk) disable iff (reset) // see RULE_06
        !$past(reset) |-> preamble_restore == ($past(mode_reg) == MODE_PRE_REST))
        else $error("preamble restore output mismatch");

    // Address output copies the latch one cycle later
    AST_ADDR_OUT: assert property (@(posedge clk) disable iff (reset) // see RULE_03
        !$past(reset) |-> mgmt_address == $past(addr_reg))
        else $error("address output mismatch");

    // Selector and unused bits never move
    AST_FIXED_BITS: assert property (@(posedge clk) disable iff (reset) // see RULE_13
        adv_reg[4:0] == ADV_SELECTOR && adv_reg[15:9] == 7'h00 && (ctrl_reg & ~CTRL_WR_MASK) == 16'h0000)
        else $error("fixed register bits changed");

    // Software write lands in the writable control bits
    AST_CTRL_WR: assert property (@(posedge clk) disable iff (reset) // see RULE_13
        !in_reset && wr_ctrl |=> ctrl_reg == ($past(reg_wdata) & CTRL_WR_MASK))
        else $error("control write not applied");

    // Software write lands in the advertised ability bits
    AST_ADV_WR: assert property (@(posedge clk) disable iff (reset) // see RULE_13
        !in_reset && wr_adv |=> adv_reg == (($past(reg_wdata) & ADV_WR_MASK) | {11'h000, ADV_SELECTOR}))
        else $error("advertisement write not applied");

    COV_RELEASE:  cover property (@(posedge clk) disable iff (reset) in_reset ##1 !in_reset [*3]);
    COV_CTRL_WR:  cover property (@(posedge clk) disable iff (reset) !in_reset && wr_ctrl ##1 reg_rd);
    COV_PREAMBLE: cover property (@(posedge clk) disable iff (reset) preamble_restore);
    COV_ADV_WR:   cover property (@(posedge clk) disable iff (reset) !in_reset && wr_adv);
    COV_CHIP_RST: cover property (@(posedge clk) disable iff (reset) !chip_reset_n ##1 chip_reset_n);
endmodule : sol_strap_option_latch
`default_nettype wire

/* sol_strap_option_latch_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module sol_strap_option_latch_tb;
    import sol_pkg::*;
    logic                 clk = 1'b0;
    logic                 reset = 1'b1;
    logic                 chip_reset_n = 1'b1;
    logic [ADDR_W-1:0]    reg_addr = 8'h00;
    logic [DATA_W-1:0]    reg_wdata = 16'h0000;
    logic                 reg_wr = 1'b0;
    logic                 reg_rd = 1'b0;
    logic [DATA_W-1:0]    reg_rdata;
    logic [NUM_STRAP-1:0] pin_in, pin_out, pin_oe, pu_en, pd_en;
    logic [NUM_STRAP-1:0] func_out = 10'h2A5;
    logic [NUM_STRAP-1:0] drive_en = 10'h000;
    logic [NUM_STRAP-1:0] drive_val = 10'h000;
    logic [4:0]           mgmt_address;
    logic                 pre_rest, iso_en, spd100, fdx, aneg;
    int                   n_fail = 0;
    int                   tests_run = 0;

    // ------------------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------------------
    // 25 MHz system clock
    always #20 clk = ~clk;

    sol_strap_option_latch dut (.clk(clk), .reset(reset), .chip_reset_n(chip_reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .strap_pin_in(pin_in),
        .strap_pin_out(pin_out), .strap_pin_oe(pin_oe), .strap_pull_up_en(pu_en), .strap_pull_dn_en(pd_en),
        .pin_func_out(func_out), .mgmt_address(mgmt_address), .preamble_restore(pre_rest),
        .isolate_en(iso_en), .speed_100(spd100), .full_duplex(fdx), .autoneg_en(aneg));

    sol_strap_board board (.clk(clk), .strap_pin_out(pin_out), .strap_pin_oe(pin_oe),
        .strap_pull_up_en(pu_en), .strap_pull_dn_en(pd_en), .drive_en(drive_en), .drive_val(drive_val),
        .strap_pin_in(pin_in));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Apply a reset with the given pin levels, then judge every strap result
    task automatic do_cap(input logic [9:0] en, input logic [9:0] v, input bit por);
        logic [9:0]  lv;
        logic [15:0] d;
        lv = (en & v) | (~en & PULL_UP_MASK);
        @(posedge clk);
        drive_en  <= en;
        drive_val <= v;
        if (por)
            reset <= 1'b1;
        else
            chip_reset_n <= 1'b0;
        repeat (por ? 20 : 4) @(posedge clk);
        #1 chk({6'h0, pu_en}, {6'h0, PULL_UP_MASK});
        chk({6'h0, pd_en}, {6'h0, ~PULL_UP_MASK});
        chk({6'h0, pin_oe}, 16'h0000);
        @(posedge clk);
        reset        <= 1'b0;
        chip_reset_n <= 1'b1;
        drive_en     <= 10'h000;
        repeat (2) @(posedge clk);
        #1 chk({6'h0, pin_oe}, 16'h03FF);
        chk({6'h0, pin_out}, {6'h0, func_out});
        chk({11'h0, mgmt_address}, {11'h0, 2'b00, lv[2:0]});
        chk({15'h0, pre_rest}, {15'h0, lv[5:3] == MODE_PRE_REST});
        chk({12'h0, iso_en, spd100, fdx, aneg}, {12'h0, lv[6], lv[7], ~lv[8], lv[9]});
        rd(CTRL_OFF, d);
        chk(d, {2'b00, lv[7], lv[9], 1'b0, lv[6], 1'b0, ~lv[8], 8'h00});
        rd(ADV_OFF, d);
        chk(d, {7'h00, lv[7], lv[7], 2'b11, 5'h01});
        rd(STAT_OFF, d);
        chk(d, {6'h00, 1'b1, lv[5:3] != MODE_MII && lv[5:3] != MODE_PRE_REST, lv[5:3], 2'b00, lv[2:0]});
    endtask : do_cap

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Power-up with every pin left at its internal pull
    task automatic test_defaults;
        do_cap(10'h000, 10'h000, 1'b1);
        $display("test_defaults done");
    endtask : test_defaults

    // Chip resets walking addresses 1 to 7, all mode codes and both levels of each option
    task automatic test_straps;
        logic [2:0] i;
        for (int k = 0; k < 8; k++) begin
            i = 3'(k);
            do_cap(10'h3FF, {~i[0], i[2], i[1], i[0], i, 3'(k % 7 + 1)}, 1'b0);
        end
        $display("test_straps done");
    endtask : test_straps

    // Pins move after reset, then software overrides the loaded bits
    task automatic test_hold;
        logic [15:0] d;
        do_cap(10'h3FF, 10'h0C3, 1'b0);
        func_out <= ~func_out;
        repeat (4) @(posedge clk);
        #1 chk({11'h0, mgmt_address}, 16'h0003);
        chk({12'h0, iso_en, spd100, fdx, aneg}, 16'h000E);
        wr(CTRL_OFF, 16'hFFFF);
        @(posedge clk);
        #1 chk({12'h0, iso_en, spd100, fdx, aneg}, 16'h000F);
        rd(CTRL_OFF, d);
        chk(d, CTRL_WR_MASK);
        wr(STAT_OFF, 16'hFFFF);
        rd(STAT_OFF, d);
        chk(d, 16'h0203);
        rd(8'h0C, d);
        chk(d, 16'h0000);
        wr(ADV_OFF, 16'hFFFF);
        rd(ADV_OFF, d);
        chk(d, 16'h01E1);
        do_cap(10'h000, 10'h000, 1'b0);
        $display("test_hold done");
    endtask : test_hold

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // Main sequence
    initial begin
        test_defaults();
        test_straps();
        test_hold();
        complete_run();
    end

    // Watchdog well beyond the expected run of under two hundred cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule : sol_strap_option_latch_tb
`default_nettype wire

/* sol_strap_pad.sv */
`timescale 1ns/10ps
`default_nettype none
module sol_strap_pad
    import sol_pkg::*;
(
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  reset,
    // Pin side
    sol_strap_if.pad   sp
);
    // ------------------------------------------------------------
    // Per-pin role switch and level capture
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < NUM_STRAP; i++) begin : g_pin
            // Level follows the pin only while reset is in progress
            always_ff @(posedge clk) begin
                if (sp.in_reset) begin
                    sp.level[i] <= sp.pin_in[i]; // see RULE_01
                end
            end

            // Weak pull and input role during reset, driver afterwards
            always_ff @(posedge clk) begin
                if (reset) begin
                    sp.pin_oe[i]  <= 1'b0;
                    sp.pin_out[i] <= 1'b0;
                    sp.pull_up[i] <= PULL_UP_MASK[i];
                    sp.pull_dn[i] <= ~PULL_UP_MASK[i];
                end else begin
                    sp.pin_oe[i]  <= ~sp.in_reset; // see RULE_02
                    sp.pin_out[i] <= sp.in_reset ? 1'b0 : sp.func_out[i];
                    sp.pull_up[i] <= sp.in_reset & PULL_UP_MASK[i];
                    sp.pull_dn[i] <= sp.in_reset & ~PULL_UP_MASK[i];
                end
            end
        end
    endgenerate
endmodule : sol_strap_pad
`default_nettype wire
